// *** hdl/cprb_pkg.sv ***
package cprb_pkg;
	// Port word width
	localparam int WORD_W = 32;
	localparam int ADDR_W = 5;
	// Session words
	localparam logic [31:0] DUMMY_WORD = 32'hFFFFFFFF;
	localparam logic [31:0] BW_SYNC_WORD = 32'h000000BB;
	localparam logic [31:0] BW_DETECT_WORD = 32'h11220044;
	localparam logic [31:0] SYNC_WORD = 32'hAA995566;
	localparam logic [31:0] NOP_WORD = 32'h20000000;
	localparam logic [31:0] HDR_CMD_WR = 32'h30008001;
	localparam logic [31:0] CMD_END_SESSION = 32'h0000000D;
	localparam logic [31:0] CMD_SNAPSHOT = 32'h0000000C;
	localparam logic [31:0] HDR_RD_BASE = 32'h28000001;
	// Header fields
	localparam int TYPE_HI = 31;
	localparam int TYPE_LO = 29;
	localparam int OP_HI = 28;
	localparam int OP_LO = 27;
	localparam int ADDR_HI = 17;
	localparam int ADDR_LO = 13;
	localparam logic [2:0] TYPE_ONE = 3'h1;
	localparam logic [1:0] OP_NOP = 2'h0;
	localparam logic [1:0] OP_RD = 2'h1;
	localparam logic [1:0] OP_WR = 2'h2;
	// Register addresses
	localparam logic [4:0] REG_CMD = 5'h04;
	localparam logic [4:0] REG_STAT = 5'h07;
	localparam logic [4:0] REG_OPTION_REGISTER_ZERO = 5'h09;
	localparam logic [31:0] OPTION_REGISTER_ZERO_RESET = 32'h00000000;
	// Status bits
	localparam int STAT_SYNCED = 0;
	localparam int STAT_ABORT = 1;
	localparam int STAT_SNAP = 2;
	localparam int STAT_DENIED = 3;
	localparam int STAT_USED = 4;
	// Flush words after a read header
	localparam logic [1:0] FLUSH_WORDS = 2'h2;
	// Host word counts
	localparam logic [3:0] OPEN_LEN = 4'h9;
	localparam logic [3:0] CLOSE_LEN = 4'h4;

	// Read header for a register, one word
	function automatic logic [31:0] hdr_read(input logic [4:0] a);
		hdr_read = HDR_RD_BASE | {14'h0000, a, 13'h0000};
	endfunction : hdr_read

	// Register address field of a header
	function automatic logic [4:0] hdr_addr(input logic [31:0] w);
		hdr_addr = w[ADDR_HI:ADDR_LO];
	endfunction : hdr_addr
endpackage : cprb_pkg

// *** hdl/cprb_port_if.sv ***
`timescale 1ns/10ps
interface cprb_port_if;
	logic cs_n;
	logic read_write_select_n;
	logic [31:0] host_data;
	logic host_oe;
	logic [31:0] dev_data;
	logic dev_oe;
	logic data_out_busy;
	logic [31:0] bus;

	// Wire level from whichever end drives
	assign bus = dev_oe ? dev_data : (host_oe ? host_data : 32'hFFFFFFFF);

	modport device (
		input cs_n,
		input read_write_select_n,
		input bus,
		output dev_data,
		output dev_oe,
		output data_out_busy
	);

	modport host (
		output cs_n,
		output read_write_select_n,
		output host_data,
		output host_oe,
		input bus,
		input data_out_busy
	);
endinterface : cprb_port_if

// *** hdl/cprb_host.sv ***
`timescale 1ns/10ps
module cprb_host #(
	parameter int READ_WAIT = 64
) (
	input wire logic mclk,
	input wire logic rst,
	cprb_port_if.host port,
	input wire logic req,
	input wire logic [4:0] req_addr,
	output logic session_busy,
	output logic done,
	output logic [31:0] rd_data,
	output logic rd_err
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SEND = 3'b001,
		H_GAPA = 3'b011,
		H_GAPB = 3'b010,
		H_READ = 3'b110,
		H_GAPC = 3'b111,
		H_GAPD = 3'b101,
		H_CLOSE = 3'b100
	} cprb_hst_t;

	cprb_hst_t st_q;
	logic cs_n_q, rw_q, done_q, err_q;
	logic [31:0] hdata_q, rdata_q;
	logic [3:0] idx_q;
	logic [4:0] addr_q;
	logic [15:0] wait_q;
	logic bsy_m_q, bsy_q;
	logic [31:0] dat_m_q, dat_q;

	// Opening words, then read header and two flushes
	function automatic logic [31:0] open_word(input logic [3:0] i,
		input logic [4:0] a);
		unique case (i)
			4'h0: open_word = cprb_pkg::DUMMY_WORD;
			4'h1: open_word = cprb_pkg::BW_SYNC_WORD;
			4'h2: open_word = cprb_pkg::BW_DETECT_WORD;
			4'h3: open_word = cprb_pkg::DUMMY_WORD;
			4'h4: open_word = cprb_pkg::SYNC_WORD;
			4'h6: open_word = cprb_pkg::hdr_read(a);
			default: open_word = cprb_pkg::NOP_WORD;
		endcase
	endfunction : open_word

	// Closing words
	function automatic logic [31:0] close_word(input logic [3:0] i);
		unique case (i)
			4'h0: close_word = cprb_pkg::HDR_CMD_WR;
			4'h1: close_word = cprb_pkg::CMD_END_SESSION;
			default: close_word = cprb_pkg::NOP_WORD;
		endcase
	endfunction : close_word

	// Port pins and user answers
	assign port.cs_n = cs_n_q;
	assign port.read_write_select_n = rw_q;
	assign port.host_data = hdata_q;
	assign port.host_oe = !cs_n_q && !rw_q;
	assign session_busy = st_q != H_IDLE;
	assign done = done_q;
	assign rd_data = rdata_q;
	assign rd_err = err_q;

	// Busy and data pass two flops before use
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bsy_m_q <= 1'b1;
			bsy_q <= 1'b1;
			dat_m_q <= 32'h00000000;
			dat_q <= 32'h00000000;
		end else begin
			bsy_m_q <= port.data_out_busy;
			bsy_q <= bsy_m_q;
			dat_m_q <= port.bus;
			dat_q <= dat_m_q;
		end
	end

	// Session sequencer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= H_IDLE;
			cs_n_q <= 1'b1;
			rw_q <= 1'b0;
			hdata_q <= 32'h00000000;
			idx_q <= 4'h0;
			addr_q <= 5'h00;
			wait_q <= 16'h0000;
			rdata_q <= 32'h00000000;
			err_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				H_IDLE: if (req) begin
					cs_n_q <= 1'b0;
					hdata_q <= open_word(4'h0, req_addr);
					addr_q <= req_addr;
					idx_q <= 4'h1;
					st_q <= H_SEND;
				end
				H_SEND: if (idx_q == cprb_pkg::OPEN_LEN) begin
					cs_n_q <= 1'b1;
					st_q <= H_GAPA;
				end else begin
					hdata_q <= open_word(idx_q, addr_q);
					idx_q <= idx_q + 4'h1;
				end
				H_GAPA: begin
					rw_q <= 1'b1;
					st_q <= H_GAPB;
				end
				H_GAPB: begin
					cs_n_q <= 1'b0;
					wait_q <= 16'h0000;
					st_q <= H_READ;
				end
				H_READ: if (!bsy_q) begin
					rdata_q <= dat_q;
					err_q <= 1'b0;
					cs_n_q <= 1'b1;
					st_q <= H_GAPC;
				end else if (wait_q == 16'(READ_WAIT)) begin
					err_q <= 1'b1;
					cs_n_q <= 1'b1;
					st_q <= H_GAPC;
				end else begin
					wait_q <= wait_q + 16'h0001;
				end
				H_GAPC: begin
					rw_q <= 1'b0;
					st_q <= H_GAPD;
				end
				H_GAPD: begin
					cs_n_q <= 1'b0;
					hdata_q <= close_word(4'h0);
					idx_q <= 4'h1;
					st_q <= H_CLOSE;
				end
				H_CLOSE: if (idx_q == cprb_pkg::CLOSE_LEN) begin
					cs_n_q <= 1'b1;
					done_q <= 1'b1;
					st_q <= H_IDLE;
				end else begin
					hdata_q <= close_word(idx_q);
					idx_q <= idx_q + 4'h1;
				end
			endcase
		end
	end
endmodule : cprb_host

// *** hdl/cprb_device.sv ***
// What this block does
// - Data pins input on write, output on read
// - Select change under chip select aborts
// - Host toggles select only with chip select high
// - Readback works running or shut down
// - Deny user memory during readback access
// - Host opens with dummy, width, sync words
// - Read header then two flush words
// - Pins carry word_q when selected for read while the port is live; busy low marks at most one word per read, none when refused
// - Host returns to write control before commands
// - Close with command header, end, two flushes
// - Any readable register readable; others refused
// - Trigger or command captures user register states
// - Without persist, pins return to user
// - Readback needs security allowed, no encryption
// - Host takes data only while busy low
`timescale 1ns/10ps
module cprb_device (
	input wire logic mclk,
	input wire logic rst,
	cprb_port_if.device port,
	input wire logic snapshot_trigger_input,
	input wire logic config_done,
	input wire logic persist_option,
	input wire logic readback_secure_ok,
	input wire logic image_encrypted,
	output logic snapshot_pulse,
	output logic user_mem_deny,
	output logic port_user_io,
	output logic session_active,
	output logic [31:0] option_register_zero
);
	typedef enum logic [1:0] {
		D_UNSYNC = 2'b00,
		D_SYNCED = 2'b01,
		D_CMD = 2'b11,
		D_COR = 2'b10
	} cprb_dst_t;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic cs_n_m_q, cs_n_q, rw_m_q, rw_q, rw_prev_q;
	logic [31:0] din_m_q, din_q;

	// Two flops on every pin input
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cs_n_m_q <= 1'b1;
			cs_n_q <= 1'b1;
			rw_m_q <= 1'b0;
			rw_q <= 1'b0;
			rw_prev_q <= 1'b0;
			din_m_q <= 32'h00000000;
			din_q <= 32'h00000000;
		end else begin
			cs_n_m_q <= port.cs_n;
			cs_n_q <= cs_n_m_q;
			rw_m_q <= port.read_write_select_n;
			rw_q <= rw_m_q;
			rw_prev_q <= rw_q;
			din_m_q <= port.bus;
			din_q <= din_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Decode

	cprb_dst_t st_q;
	logic abort_q, snap_q, denied_q, snap_pulse_q, trig_prev_q;
	logic rd_pend_q, word_rdy_q;
	logic [1:0] flush_q;
	logic [4:0] rd_addr_q;
	logic [31:0] word_q, cor_q;
	logic port_live, rd_ok, wr_word, abort_ev, drive_word;
	logic is_type1, is_nop, is_rd, is_wr, sync_ev;
	logic flush_done, readable, trig_ev, cmd_snap;
	logic [4:0] w_addr;
	logic [31:0] stat_val, reg_val;

	// Port stays a config port only with persist
	assign port_live = !config_done || persist_option;
	// Security and encryption gate all reads
	assign rd_ok = readback_secure_ok && !image_encrypted;
	// A written word is taken each selected write cycle
	assign wr_word = port_live && !cs_n_q && !rw_q;
	// Select moved while chip select held low
	assign abort_ev = port_live && !cs_n_q && (rw_q != rw_prev_q);

	// Header fields of the incoming word
	assign is_type1 = din_q[cprb_pkg::TYPE_HI:cprb_pkg::TYPE_LO]
		== cprb_pkg::TYPE_ONE;
	assign is_nop = is_type1
		&& din_q[cprb_pkg::OP_HI:cprb_pkg::OP_LO] == cprb_pkg::OP_NOP;
	assign is_rd = is_type1
		&& din_q[cprb_pkg::OP_HI:cprb_pkg::OP_LO] == cprb_pkg::OP_RD;
	assign is_wr = is_type1
		&& din_q[cprb_pkg::OP_HI:cprb_pkg::OP_LO] == cprb_pkg::OP_WR;
	assign w_addr = cprb_pkg::hdr_addr(din_q);
	assign sync_ev = wr_word && din_q == cprb_pkg::SYNC_WORD;

	// Registers with read access
	assign readable = w_addr == cprb_pkg::REG_STAT
		|| w_addr == cprb_pkg::REG_OPTION_REGISTER_ZERO;
	assign stat_val = {28'h0000000, denied_q, snap_q, abort_q,
		st_q != D_UNSYNC};
	// Not gated by any user design state, so works in shutdown
	assign reg_val = (rd_addr_q == cprb_pkg::REG_OPTION_REGISTER_ZERO) ? cor_q
		: stat_val;
	assign flush_done = rd_pend_q && wr_word && is_nop
		&& st_q == D_SYNCED && flush_q == cprb_pkg::FLUSH_WORDS - 2'h1;

	// Capture requests from trigger edge or command word
	assign trig_ev = snapshot_trigger_input && !trig_prev_q;
	assign cmd_snap = st_q == D_CMD && wr_word
		&& din_q == cprb_pkg::CMD_SNAPSHOT;

	////////////////////////////////////////////////////////////////////
	// Packet state

	// Sync hunt and command decode
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q <= D_UNSYNC;
			cor_q <= cprb_pkg::OPTION_REGISTER_ZERO_RESET;
		end else if (abort_ev) begin
			st_q <= D_UNSYNC;
		end else if (wr_word) begin
			unique case (st_q)
				D_UNSYNC: if (sync_ev) begin
					st_q <= D_SYNCED;
				end
				D_SYNCED: if (is_wr && w_addr == cprb_pkg::REG_CMD) begin
					st_q <= D_CMD;
				end else if (is_wr && w_addr == cprb_pkg::REG_OPTION_REGISTER_ZERO) begin
					st_q <= D_COR;
				end
				D_CMD: if (din_q == cprb_pkg::CMD_END_SESSION) begin
					st_q <= D_UNSYNC;
				end else begin
					st_q <= D_SYNCED;
				end
				D_COR: begin
					cor_q <= din_q;
					st_q <= D_SYNCED;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path

	// Read header arms, flushes ready the word
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= 5'h00;
			flush_q <= 2'h0;
		end else if (abort_ev || st_q == D_UNSYNC) begin
			rd_pend_q <= 1'b0;
		end else if (wr_word && st_q == D_SYNCED && is_rd) begin
			rd_pend_q <= rd_ok && readable;
			rd_addr_q <= w_addr;
			flush_q <= 2'h0;
		end else if (flush_done) begin
			rd_pend_q <= 1'b0;
		end else if (rd_pend_q && wr_word && is_nop) begin
			flush_q <= flush_q + 2'h1;
		end
	end

	// One word offered per armed read
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			word_rdy_q <= 1'b0;
			word_q <= 32'h00000000;
		end else if (flush_done) begin
			word_rdy_q <= 1'b1;
			word_q <= reg_val;
		end else if (drive_word || abort_ev || wr_word) begin
			word_rdy_q <= 1'b0;
		end
	end

	// Status flags, set wins over clear on sync
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			abort_q <= 1'b0;
			snap_q <= 1'b0;
			denied_q <= 1'b0;
		end else begin
			abort_q <= abort_ev || (abort_q && !sync_ev);
			snap_q <= trig_ev || cmd_snap || (snap_q && !sync_ev);
			denied_q <= (wr_word && st_q == D_SYNCED && is_rd
				&& !(rd_ok && readable)) || (denied_q && !sync_ev);
		end
	end

	// Capture strobe to the user register fabric
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trig_prev_q <= 1'b0;
			snap_pulse_q <= 1'b0;
		end else begin
			trig_prev_q <= snapshot_trigger_input;
			snap_pulse_q <= trig_ev || cmd_snap;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pins and user outputs

	// Drive only while selected for read
	assign port.dev_oe = port_live && !cs_n_q && rw_q;
	assign drive_word = port.dev_oe && word_rdy_q;
	assign port.dev_data = word_q;
	// Busy low marks the one valid word
	assign port.data_out_busy = !drive_word;
	// Config logic owns memories while a read is armed
	assign user_mem_deny = rd_pend_q || word_rdy_q;
	assign snapshot_pulse = snap_pulse_q;
	assign port_user_io = !port_live;
	assign session_active = st_q != D_UNSYNC;
	assign option_register_zero = cor_q;
endmodule : cprb_device

// *** dv/cprb_assertions.sv ***
`timescale 1ns/10ps
module cprb_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic read_write_select_n,
	input wire logic [31:0] host_data,
	input wire logic host_oe,
	input wire logic [31:0] dev_data,
	input wire logic dev_oe,
	input wire logic data_out_busy,
	input wire logic [31:0] bus
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// Host word streams
	sequence s_open;
		host_data == cprb_pkg::DUMMY_WORD ##1
		host_data == cprb_pkg::BW_SYNC_WORD ##1
		host_data == cprb_pkg::BW_DETECT_WORD ##1
		host_data == cprb_pkg::DUMMY_WORD ##1
		host_data == cprb_pkg::SYNC_WORD ##1
		host_data == cprb_pkg::NOP_WORD;
	endsequence
	sequence s_read_hdr;
		host_data[31:29] == cprb_pkg::TYPE_ONE &&
		host_data[28:27] == cprb_pkg::OP_RD ##1
		host_data == cprb_pkg::NOP_WORD ##1
		host_data == cprb_pkg::NOP_WORD ##1 cs_n;
	endsequence
	sequence s_close;
		host_data == cprb_pkg::CMD_END_SESSION ##1
		host_data == cprb_pkg::NOP_WORD ##1
		host_data == cprb_pkg::NOP_WORD ##1 cs_n;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Wire ownership and direction
	AST_OE_READ_ONLY: assert property (
		dev_oe |-> !$past(cs_n, 2) && $past(read_write_select_n, 2))
		else $error("device drove pins outside a read");
	AST_BUS_FROM_DEV: assert property (
		dev_oe |-> bus == dev_data)
		else $error("pins do not carry the device word");
	AST_NO_CONTENTION: assert property (
		!(dev_oe && host_oe))
		else $error("both ends drive the pins");
	AST_HOST_OE_WRITE: assert property (
		host_oe == (!cs_n && !read_write_select_n))
		else $error("host drive enable wrong for direction");
	AST_RW_UNDER_CS_HIGH: assert property (
		$changed(read_write_select_n) |-> cs_n && $past(cs_n))
		else $error("direction changed with chip select low");
	AST_OE_RELEASE: assert property (
		$rose(cs_n) |-> ##[1:3] !dev_oe)
		else $error("device kept driving after deselect");
	// Read answer
	AST_BUSY_WITH_OE: assert property (
		!data_out_busy |-> dev_oe)
		else $error("word offered without drive");
	AST_ONE_WORD: assert property (
		!data_out_busy |=> data_out_busy [*8])
		else $error("more than one word per read");
	// Session framing
	AST_OPEN_SEQ: assert property (
		$fell(cs_n) && !read_write_select_n &&
		host_data == cprb_pkg::DUMMY_WORD |-> s_open ##1 s_read_hdr)
		else $error("session open words out of order");
	AST_CLOSE_SEQ: assert property (
		$fell(cs_n) && !read_write_select_n &&
		host_data == cprb_pkg::HDR_CMD_WR |-> ##1 s_close)
		else $error("session close words out of order");
endmodule : cprb_assertions

// *** dv/config_port_register_readback_tb.sv ***
`timescale 1ns/10ps
module config_port_register_readback_tb;
	logic mclk, rst, req, trig, cdone, persist, sec_ok, enc;
	logic [4:0] req_addr;
	logic snapshot_pulse, user_mem_deny, port_user_io, session_active;
	logic session_busy, done, rd_err;
	logic [31:0] option_register_zero, rd_data;
	logic [31:0] seed;
	logic snap_on;
	int failures, num_checks, i, n, j;

	////////////////////////////////////////////////////////////////////////
	// Both ends joined across the port
	cprb_port_if port_if ();
	cprb_device u_cprb_device (.mclk(mclk), .rst(rst), .port(port_if),
		.snapshot_trigger_input(trig), .config_done(cdone),
		.persist_option(persist), .readback_secure_ok(sec_ok),
		.image_encrypted(enc), .snapshot_pulse(snapshot_pulse),
		.user_mem_deny(user_mem_deny), .port_user_io(port_user_io),
		.session_active(session_active),
		.option_register_zero(option_register_zero));
	cprb_host #(.READ_WAIT(16)) u_cprb_host (.mclk(mclk), .rst(rst),
		.port(port_if), .req(req), .req_addr(req_addr),
		.session_busy(session_busy), .done(done), .rd_data(rd_data),
		.rd_err(rd_err));
	cprb_assertions u_cprb_assertions (.mclk(mclk), .rst(rst),
		.cs_n(port_if.cs_n),
		.read_write_select_n(port_if.read_write_select_n),
		.host_data(port_if.host_data), .host_oe(port_if.host_oe),
		.dev_data(port_if.dev_data), .dev_oe(port_if.dev_oe),
		.data_out_busy(port_if.data_out_busy), .bus(port_if.bus));

	////////////////////////////////////////////////////////////////////////
	// Compare helpers and expectations
	task cmp32(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp32
	task cmp1(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp1
	function logic exp_err(input logic [4:0] a);
		exp_err = !(a == cprb_pkg::REG_STAT || a == cprb_pkg::REG_OPTION_REGISTER_ZERO) ||
			!sec_ok || enc || (cdone && !persist);
	endfunction : exp_err
	function logic [31:0] exp_word(input logic [4:0] a);
		exp_word = (a == cprb_pkg::REG_STAT) ?
			(32'h00000001 | (32'(snap_on) << cprb_pkg::STAT_SNAP)) :
			cprb_pkg::OPTION_REGISTER_ZERO_RESET;
	endfunction : exp_word

	// One register read through the host, with side effects watched
	task do_read(input logic [4:0] a);
		int k;
		logic d, s;
		d = 1'b0;
		s = 1'b0;
		@(negedge mclk);
		req = 1'b1;
		req_addr = a;
		@(negedge mclk);
		req = 1'b0;
		cmp1("session_busy", 1'b1, session_busy);
		k = 0;
		while (done !== 1'b1 && k < 300) begin
			@(posedge mclk);
			#1;
			if (user_mem_deny === 1'b1) d = 1'b1;
			if (session_active === 1'b1) s = 1'b1;
			k++;
		end
		if (k == 300) begin
			failures++;
			wrap_up();
		end
		cmp1("session_busy at done", 1'b0, session_busy);
		cmp1("rd_err", exp_err(a), rd_err);
		if (!exp_err(a)) cmp32("rd_data", exp_word(a), rd_data);
		cmp1("user_mem_deny seen", !exp_err(a), d);
		cmp1("session seen", !(cdone && !persist), s);
		repeat (4) @(negedge mclk);
		cmp1("session_active after close", 1'b0, session_active);
	endtask : do_read

	task wrap_up;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#400000;
		failures++;
		wrap_up();
	end

	// Main sequence
	initial begin
		seed = 32'hA3AA4CC6;
		snap_on = 1'b0;
		{req, trig, cdone, persist, enc} = 5'h00;
		sec_ok = 1'b1;
		req_addr = 5'h00;
		rst = 1'b1;
		repeat (5) @(negedge mclk);
		cmp1("cs_n in reset", 1'b1, port_if.cs_n);
		cmp1("dev_oe in reset", 1'b0, port_if.dev_oe);
		cmp1("busy in reset", 1'b1, port_if.data_out_busy);
		cmp1("session in reset", 1'b0, session_active);
		cmp32("option_register_zero reset", cprb_pkg::OPTION_REGISTER_ZERO_RESET, option_register_zero);
		rst = 1'b0;
		$display("test reset done");
		// Readable registers back to back
		do_read(cprb_pkg::REG_STAT);
		do_read(cprb_pkg::REG_OPTION_REGISTER_ZERO);
		do_read(cprb_pkg::REG_STAT);
		$display("test readable done");
		// Corners then random addresses, then status flags re-cleared
		for (i = 0; i < 9; i++) begin
			n = $random(seed);
			if (i == 0) n = 0;
			if (i == 1) n = 31;
			if (i == 2) n = cprb_pkg::REG_CMD;
			do_read(n[4:0]);
		end
		do_read(cprb_pkg::REG_STAT);
		$display("test refused done");
		// Every mix of done, persist, security and encryption
		for (i = 0; i < 16; i++) begin
			@(negedge mclk);
			{cdone, persist, sec_ok, enc} = i[3:0];
			@(negedge mclk);
			cmp1("port_user_io", cdone && !persist, port_user_io);
			do_read(cprb_pkg::REG_STAT);
		end
		{cdone, persist, sec_ok, enc} = 4'h2;
		do_read(cprb_pkg::REG_OPTION_REGISTER_ZERO);
		$display("test options done");
		// Short and long trigger each give one capture pulse
		for (i = 0; i < 2; i++) begin
			@(negedge mclk);
			trig = 1'b1;
			n = 0;
			for (j = 0; j < 8; j++) begin
				@(negedge mclk);
				if (snapshot_pulse === 1'b1) n++;
				if (j == i * 5) trig = 1'b0;
			end
			cmp1("one snapshot pulse", 1'b1, n == 1);
		end
		// Trigger inside a session shows in the status word
		snap_on = 1'b1;
		fork
			do_read(cprb_pkg::REG_STAT);
			begin
				repeat (9) @(negedge mclk);
				trig = 1'b1;
				@(negedge mclk);
				trig = 1'b0;
			end
		join
		snap_on = 1'b0;
		$display("test snapshot done");
		wrap_up();
	end
endmodule : config_port_register_readback_tb
